// [rtl/dscp_map.svh]
// Purpose: Constants of the delay system control path
// Assumes: 125 MHz system clock
// Notes:   Offsets are byte addresses on the register bus
`ifndef DSCP_MAP_SVH
`define DSCP_MAP_SVH
// Host word framing and routing codes (word bits 23..20)
`define DSCP_WLAST   6'd31
`define DSCP_RT_LO   20
`define DSCP_RT_CTL  4'h0
`define DSCP_RT_DLY  4'h1
`define DSCP_RT_RMA  4'h2
`define DSCP_RT_TIME 4'h3
`define DSCP_CW_OBS  0
// Delay words, transfer pacing, test offset
`define DSCP_LASTDLY 6'd53
`define DSCP_STEP    4'd9
`define DSCP_TEST_OFS 16'h0005
// Sequencer period: 1.6 us held at least, rounded up
`define DSCP_SEQ_NS  1600
`define DSCP_CLK_MHZ 125
`define DSCP_SEQ_CYC ((`DSCP_SEQ_NS*`DSCP_CLK_MHZ+999)/1000)
// Word store layout and sequencer burst lengths
`define DSCP_DEPTH   4096
`define DSCP_NMULT   12'd3024
`define DSCP_ACC_BASE 12'd3078
`define DSCP_ACC_END 12'd3081
`define DSCP_LOAD_N  13'd3647
`define DSCP_RMW_N   13'd6048
`define DSCP_XMIT_N  13'd702
`define DSCP_NEG_BIT 21
`define DSCP_PERR_MAX 7'd64
`define DSCP_BLK_BT  2'd2
// Register byte offsets
`define DSCP_R_CTRL  8'h00
`define DSCP_R_STAT  8'h04
`define DSCP_R_MUX   8'h08
`define DSCP_R_PERR  8'h0c
`define DSCP_R_SADR  8'h10
`define DSCP_R_SDAT  8'h14
`define DSCP_R_TERM  8'h18
// Control register bits
`define DSCP_CB_TEST 0
`define DSCP_CB_CMP3 1
`define DSCP_CB_PFCL 2
`define DSCP_CB_ERCL 3
`define DSCP_CB_LOOP 8
`endif

// [rtl/dscp_pkg.sv]
// Purpose: Types of the delay system control path
// Assumes: Constants come from dscp_map.svh
// Notes:   Whole module state is one packed struct
package dscp_pkg;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_RMW, SEQ_XMIT}
      dscp_seq_t;
   typedef struct packed {
      logic [2:0]  hs;      // Word clock synchroniser and delay
      logic [1:0]  hd;
      logic [2:0]  p1, p2, p3; // {startup, short tick, period tick}
      logic [31:0] sr;
      logic [5:0]  bitcnt;
      logic [2:0]  lead;
      logic        hold;
      logic [31:0] ctl, tword;
      logic [11:0] rma;
      logic [5:0]  dw_cnt;
      logic [7:0]  word_num;
      logic [6:0]  perr_cnt;
      logic [5:0]  perr_idx;
      logic [2:0]  bt_idx;
      logic [53:0] hold_a, hold_b, acc;
      logic        alarm, sub_a, sub_b, xdone;
      logic [5:0]  mux_a, mux_b, mux_o;
      logic        obs_prev, host_ctl, blk, term_rst;
      logic [1:0]  blk_cnt;
      logic [3:0]  term_pc;
      logic [11:0] creg;
      logic        dx_busy, dv;
      logic [5:0]  dx_idx;
      logic [3:0]  dx_step;
      logic [15:0] dout, test_a, test_b;
      dscp_seq_t   seq;
      logic [7:0]  tcnt;
      logic [3:0]  loop;
      logic [12:0] pc;
      logic [11:0] addr, sadr;
      logic [23:0] xword;
      logic        xv, hit;
      logic        waitreq;
      logic [31:0] rdata;
   } dscp_state_t;
endpackage

// [rtl/dscp_ctrl.sv]
// Purpose: Control path of a correlator system controller
// Assumes: Pass/fail, strobe and multiplier inputs share clk_in
// Notes:   Word clock, ticks and startup pulse are async pins
// Summary of operation
// [RULE1] Each host word is 32 clocked bits
// [RULE2] Host clock toggles only during a word
// [RULE3] Leading one chain stops clock, routes word
// [RULE4] Bad parity keeps old delay word, logs
// [RULE5] 54 delay words in 64-deep stepped store
// [RULE6] Observation lights indicator, blocks entry plus two ticks
// [RULE7] Observation start resets terminal sequencer, tests, lights
// [RULE8] Transfer every short tick, store on period
// [RULE9] Capture two pass/fail words each short tick
// [RULE10] Strobes OR holding words into accumulator
// [RULE11] Accumulator kept until cleared, stored each period
// [RULE12] Period tick decides alarm and substitution
// [RULE13] Log bad-parity word numbers, 64 per period
// [RULE14] Mux addresses advance; substituted input freezes
// [RULE15] Terminal presets addresses; test generator advances them
// [RULE16] Two comparators load two test delay outputs
// [RULE17] Sequencer steps at most every 1.6 us
// [RULE18] Main cycle: load, read-modify-write, transmit
// [RULE19] Transmit compares address, 12 or 3 bits
// [RULE20] Lookup places results, gives negate and code
// [RULE21] Store is 4096 words of 24 bits
// [RULE22] Address presets then steps for set count
// [RULE23] Startup pulse resets all controller logic
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`include "dscp_map.svh"
module dscp_ctrl
   import dscp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Host serial link and timing pins
   input  wire logic        hclk_in,
   input  wire logic        hdat_in,
   input  wire logic        bt_in,
   input  wire logic        dt_in,
   input  wire logic        su_in,
   output logic             hold_out,
   // Delay section
   input  wire logic [53:0] pf_a_in,
   input  wire logic [53:0] pf_b_in,
   input  wire logic        xc1_in,
   input  wire logic        xc2_in,
   output logic [15:0]      dly_word_out,
   output logic             dly_valid_out,
   output logic [15:0]      test_a_out,
   output logic [15:0]      test_b_out,
   // Multiplier results and host transmit
   input  wire logic [19:0] mult_in,
   output logic [23:0]      xmit_word_out,
   output logic             xmit_valid_out,
   output logic             cmp_hit_out,
   // Panel and terminal
   output logic             alarm_out,
   output logic             host_ctl_out,
   output logic             entry_block_out,
   output logic             term_reset_out,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out
);
   dscp_state_t r, n;
   logic [15:0] dmem [0:63];
   logic [23:0] smem [0:`DSCP_DEPTH-1]; // [RULE21]
   logic [10:0] pmem [0:63];
   logic [23:0] sq;
   logic        dm_we, st_we, pe_we;
   logic [5:0]  dm_wa;
   logic [11:0] st_ra;
   logic [23:0] st_wd;

   // Wrap a mux address over the 54 delay lines
   function automatic logic [5:0] inc54(input logic [5:0] a);
      inc54 = (a == `DSCP_LASTDLY) ? 6'h00 : a + 6'h01;
   endfunction

   // Lookup: {reference code, negate} for a load index
   function automatic logic [2:0] lut(input logic [11:0] i);
      if (i < `DSCP_NMULT) begin
         lut = {i[1:0], i[2] ^ i[5]};
      end else begin
         lut = 3'h6;
      end
   endfunction

   logic        hrise, bt_t, dt_t, su, tick, bus_go, bus_wr, good;
   logic [53:0] acc_sh;
   logic [2:0]  lv;
   logic [11:0] idx;
   logic [15:0] dw;

   // Next-state logic of the whole block
   always_comb begin
      n = r;
      dm_we = 1'b0;
      st_we = 1'b0;
      pe_we = 1'b0;
      dm_wa = r.dw_cnt;
      st_wd = 24'h000000;
      idx = r.pc[11:0];
      lv = lut(idx);
      acc_sh = r.acc >> (18 * (idx - `DSCP_ACC_BASE));
      dw = dmem[r.dx_idx];
      good = ^r.sr; // Odd parity over the whole word
      // Second and third stages only; first stages feed nothing else
      n.hs = {r.hs[1:0], hclk_in};
      n.hd = {r.hd[0], hdat_in};
      n.p1 = {su_in, bt_in, dt_in};
      n.p2 = r.p1;
      n.p3 = r.p2;
      hrise = r.hs[1] & ~r.hs[2];
      bt_t = r.p2[1] & ~r.p3[1];
      dt_t = r.p2[0] & ~r.p3[0];
      su = r.p2[2];
      n.dv = 1'b0;
      n.xv = 1'b0;
      n.term_rst = 1'b0;
      n.xdone = 1'b0;
      n.lead = {r.lead[1:0], 1'b0}; // [RULE3]
      // Serial receive, one bit per word clock edge
      // Relies on the host clock resting between words
      if (hrise && !r.hold) begin // [RULE2]
         n.sr = {r.sr[30:0], r.hd[1]}; // [RULE1]
         n.bitcnt = r.bitcnt + 6'h01;
         if (r.bitcnt == `DSCP_WLAST) begin
            n.bitcnt = 6'h00;
            n.hold = 1'b1; // [RULE3]
            n.lead[0] = r.sr[30];
         end
      end
      // Route the finished word by its control bits
      if (r.lead[2]) begin
         n.hold = 1'b0;
         n.word_num = r.word_num + 8'h01; // [RULE13]
         case (r.sr[`DSCP_RT_LO +: 4]) // [RULE3]
            `DSCP_RT_CTL: if (good) n.ctl = r.sr;
            `DSCP_RT_DLY: begin
               dm_we = good; // [RULE4]
               n.dw_cnt = r.dw_cnt + 6'h01;
            end
            `DSCP_RT_RMA: if (good) n.rma = r.sr[11:0];
            `DSCP_RT_TIME: if (good) n.tword = r.sr;
            default: ;
         endcase
         if (!good && r.perr_cnt != `DSCP_PERR_MAX) begin
            pe_we = 1'b1; // [RULE4] [RULE13]
            n.perr_cnt = r.perr_cnt + 7'h01;
         end
      end
      // Observation indicator, entry lockout, terminal reset
      n.obs_prev = r.ctl[`DSCP_CW_OBS];
      n.host_ctl = r.ctl[`DSCP_CW_OBS]; // [RULE6]
      if (r.ctl[`DSCP_CW_OBS]) begin
         n.blk_cnt = `DSCP_BLK_BT; // [RULE6]
      end else if (bt_t && r.blk_cnt != 2'h0) begin
         n.blk_cnt = r.blk_cnt - 2'h1;
      end
      n.blk = r.ctl[`DSCP_CW_OBS] || n.blk_cnt != 2'h0;
      if (r.ctl[`DSCP_CW_OBS] && !r.obs_prev) begin
         n.term_rst = 1'b1; // [RULE7]
      end
      // Sequencer period counter, restarted on state change
      tick = r.tcnt == 8'(`DSCP_SEQ_CYC - 1);
      n.tcnt = tick ? 8'h00 : r.tcnt + 8'h01;
      // Terminal sequencer and delay test generator
      if (tick && r.creg[`DSCP_CB_TEST]) begin
         n.term_pc = r.term_pc + 4'h1;
         n.mux_a = inc54(r.mux_a); // [RULE15]
         n.mux_b = inc54(r.mux_b);
         n.mux_o = inc54(r.mux_o);
      end
      // Short tick: capture results and start the transfer
      if (bt_t) begin
         n.hold_a = pf_a_in; // [RULE9]
         n.hold_b = pf_b_in; // [RULE9]
         n.bt_idx = r.bt_idx + 3'h1;
         n.dx_busy = 1'b1; // [RULE8]
         n.dx_idx = 6'h00;
         n.dx_step = 4'h0;
      end else if (r.dx_busy) begin
         // Pulse generator advances the delay store every 10 clocks
         n.dx_step = r.dx_step + 4'h1;
         if (r.dx_step == `DSCP_STEP) begin // [RULE5]
            n.dx_step = 4'h0;
            n.dv = 1'b1;
            n.dout = {r.sub_a && r.dx_idx == r.mux_a,
                      r.sub_b && r.dx_idx == r.mux_b, dw[13:0]}; // [RULE12]
            if (r.dx_idx == r.mux_a) begin
               n.test_a = dw - `DSCP_TEST_OFS; // [RULE16]
            end
            if (r.dx_idx == r.mux_b) begin
               n.test_b = dw - `DSCP_TEST_OFS; // [RULE16]
            end
            n.dx_idx = r.dx_idx + 6'h01;
            n.dx_busy = r.dx_idx != `DSCP_LASTDLY;
         end
      end
      // Exchange strobes fold holding words into accumulator
      if (xc1_in) begin
         n.acc = n.acc | r.hold_a; // [RULE10]
      end
      if (xc2_in) begin
         n.acc = n.acc | r.hold_b; // [RULE10]
      end
      // Period tick: exchange decision, restart logs and cycle
      if (dt_t) begin
         n.alarm = |(r.hold_a | r.hold_b); // [RULE12]
         n.sub_a = r.sub_a | r.hold_a[r.mux_a]; // [RULE12]
         n.sub_b = r.sub_b | r.hold_b[r.mux_b];
         n.xdone = 1'b1;
         n.perr_cnt = 7'h00;
         n.bt_idx = 3'h0;
         n.word_num = 8'h00;
         n.dw_cnt = 6'h00;
      end
      // Step mux addresses after the decision
      if (r.xdone && !r.creg[`DSCP_CB_TEST]) begin
         if (!r.sub_a) n.mux_a = inc54(r.mux_a); // [RULE14]
         if (!r.sub_b) n.mux_b = inc54(r.mux_b); // [RULE14]
         n.mux_o = inc54(r.mux_o); // [RULE14]
      end
      // Main sequencer; LOAD, RMW and XMIT each held for whole periods, IDLE left on the period tick
      st_ra = r.addr;
      case (r.seq)
         SEQ_IDLE: begin
            st_ra = r.sadr;
            if (dt_t) begin // [RULE18]
               n.seq = SEQ_LOAD;
               n.pc = 13'h0000;
               n.addr = 12'h000;
               n.tcnt = 8'h00;
               n.loop = r.creg[`DSCP_CB_LOOP +: 4];
            end
         end
         SEQ_LOAD: begin
            if (r.pc != `DSCP_LOAD_N) begin
               st_we = 1'b1; // [RULE8]
               n.pc = r.pc + 13'h0001;
               n.addr = r.addr + 12'h001; // [RULE22]
               if (idx < `DSCP_NMULT) begin
                  st_wd = {lv, 1'b0, mult_in}; // [RULE20]
               end else if (idx < `DSCP_ACC_BASE) begin
                  st_wd = {8'h00, dmem[6'(idx - `DSCP_NMULT)]};
               end else if (idx < `DSCP_ACC_END) begin
                  st_wd = {6'h00, acc_sh[17:0]}; // [RULE11]
               end else begin
                  st_wd = r.ctl[23:0];
               end
            end
         end
         SEQ_RMW: begin
            if (r.pc != `DSCP_RMW_N) begin
               n.pc = r.pc + 13'h0001;
               if (r.pc[0]) begin
                  st_we = 1'b1;
                  st_wd = sq;
                  if (sq[`DSCP_NEG_BIT]) begin
                     st_wd[19:0] = ~sq[19:0]; // One's complement
                  end
                  n.addr = r.addr + 12'h001;
               end
            end
         end
         SEQ_XMIT: begin
            if (r.pc != `DSCP_XMIT_N) begin
               n.pc = r.pc + 13'h0001;
               if (r.pc[0]) begin
                  n.xword = sq;
                  n.xv = 1'b1;
                  n.addr = r.addr + 12'h001; // [RULE22]
                  n.hit = r.creg[`DSCP_CB_CMP3] ?
                     r.addr[2:0] == r.tword[2:0] :
                     r.addr == r.tword[11:0]; // [RULE19]
               end
            end
         end
         default: n.seq = SEQ_IDLE;
      endcase
      if (r.seq != SEQ_IDLE && tick && (st_we || n.pc == r.pc)) begin
         // Burst done and a whole period elapsed: count down loop or advance
         if (n.pc == r.pc && r.loop != 4'h0) begin
            n.loop = r.loop - 4'h1; // [RULE17]
         end else if (n.pc == r.pc) begin
            n.loop = r.creg[`DSCP_CB_LOOP +: 4];
            n.pc = 13'h0000;
            n.tcnt = 8'h00; // [RULE17]
            n.addr = 12'h000;
            case (r.seq)
               SEQ_LOAD: n.seq = SEQ_RMW;
               SEQ_RMW: begin
                  n.seq = SEQ_XMIT;
                  n.addr = r.rma; // [RULE22]
               end
               default: n.seq = SEQ_IDLE;
            endcase
         end
      end
      // Avalon slave: answer then complete on the low-wait edge
      bus_go = avs_read_in | avs_write_in;
      bus_wr = avs_write_in && bus_go && !r.waitreq;
      if (bus_go && r.waitreq) begin
         n.waitreq = 1'b0;
         case (avs_address_in)
            `DSCP_R_CTRL: n.rdata = {20'h00000, r.creg};
            `DSCP_R_STAT: n.rdata = {9'h000, r.seq, r.alarm, r.sub_a,
               r.sub_b, r.host_ctl, r.blk, r.hold, r.perr_cnt, r.word_num};
            `DSCP_R_MUX: n.rdata = {10'h000, r.mux_o, 2'h0, r.mux_b,
               2'h0, r.mux_a};
            `DSCP_R_PERR: n.rdata = {21'h000000, pmem[r.perr_idx]};
            `DSCP_R_SADR: n.rdata = {20'h00000, r.sadr};
            `DSCP_R_SDAT: n.rdata = {8'h00, sq};
            default: n.rdata = 32'h00000000;
         endcase
      end else begin
         n.waitreq = 1'b1;
      end
      if (bus_wr) begin
         case (avs_address_in)
            `DSCP_R_CTRL: begin
               n.creg = avs_writedata_in[11:0];
               if (avs_writedata_in[`DSCP_CB_PFCL]) begin
                  n.acc = 54'h0; // [RULE11]
               end
               if (avs_writedata_in[`DSCP_CB_ERCL]) begin
                  n.sub_a = 1'b0; // [RULE14]
                  n.sub_b = 1'b0;
               end
            end
            `DSCP_R_MUX: begin
               n.mux_a = avs_writedata_in[5:0]; // [RULE15]
               n.mux_b = avs_writedata_in[13:8];
               n.mux_o = avs_writedata_in[21:16];
            end
            `DSCP_R_PERR: n.perr_idx = avs_writedata_in[5:0];
            `DSCP_R_SADR: n.sadr = avs_writedata_in[11:0];
            `DSCP_R_TERM: if (!r.blk && !r.hold) begin
               n.sr = avs_writedata_in; // [RULE6]
               n.hold = 1'b1;
               n.lead[0] = 1'b1;
            end
            default: ;
         endcase
      end
      // Observation start clears terminal work and lamps
      if (r.term_rst) begin
         n.term_pc = 4'h0; // [RULE7]
         n.creg[`DSCP_CB_TEST] = 1'b0;
         n.alarm = 1'b0;
      end
      // Startup pulse returns everything to rest
      if (su) begin
         n = '0; // [RULE23]
         n.p1 = {su_in, bt_in, dt_in};
         n.p2 = r.p1; // Chain keeps running so the pulse can end
         n.p3 = r.p2;
         n.waitreq = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         r <= '0;
         r.waitreq <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Memories: delay store, word store, parity log
   always_ff @(posedge clk_in) begin
      if (dm_we) begin
         dmem[dm_wa] <= r.sr[15:0]; // [RULE5]
      end
      if (st_we) begin
         smem[r.addr] <= st_wd;
      end
      if (pe_we) begin
         pmem[r.perr_cnt[5:0]] <= {r.bt_idx, r.word_num}; // [RULE13]
      end
      sq <= smem[st_ra];
   end

   // Outputs straight from state flops
   assign hold_out            = r.hold;
   assign dly_word_out        = r.dout;
   assign dly_valid_out       = r.dv;
   assign test_a_out          = r.test_a;
   assign test_b_out          = r.test_b;
   assign xmit_word_out       = r.xword;
   assign xmit_valid_out      = r.xv;
   assign cmp_hit_out         = r.hit;
   assign alarm_out           = r.alarm;
   assign host_ctl_out        = r.host_ctl;
   assign entry_block_out     = r.blk;
   assign term_reset_out      = r.term_rst;
   assign avs_readdata_out    = r.rdata;
   assign avs_waitrequest_out = r.waitreq;
endmodule

// [tb/dscp_ctrl_assertions.sv]
// Purpose: Port-level checks of the delay system control path
// Assumes: One clock domain, async reset active high
// Notes:   Bound to every dscp_ctrl instance below the module
module dscp_ctrl_assertions (
   // Clock, reset and bus handshake
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   // Link, transfer and panel outputs
   input wire logic hold_out,
   input wire logic dly_valid_out,
   input wire logic xmit_valid_out,
   input wire logic term_reset_out,
   input wire logic host_ctl_out,
   input wire logic entry_block_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // Bus answers exactly one cycle after a request is taken
   chk_wait_answer: assert property ((avs_read_in || avs_write_in) &&
      avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("waitrequest not low one cycle after request");
   chk_wait_pulse: assert property (!avs_waitrequest_out |=>
      avs_waitrequest_out) else $error("waitrequest low too long");
   chk_wait_idle: assert property (!avs_read_in && !avs_write_in &&
      avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer without request");
   // Word clock stop stands three cycles
   chk_hold_width: assert property ($rose(hold_out) |=>
      hold_out ##1 hold_out ##1 !hold_out)
      else $error("hold width not three cycles");
   // Observation start reset is a single pulse with host control
   chk_term_pulse: assert property (term_reset_out |=>
      !term_reset_out) else $error("terminal reset too long");
   chk_term_obs: assert property (term_reset_out |->
      ##[0:2] host_ctl_out) else $error("terminal reset without obs");
   // Entry stays blocked while the host has control
   chk_block_obs: assert property (host_ctl_out |=>
      entry_block_out) else $error("entry open during observation");
   chk_block_fall: assert property ($fell(entry_block_out) |->
      !host_ctl_out) else $error("entry unblocked during obs");
   // Delay words paced ten clocks apart, host words two
   chk_dly_space: assert property (dly_valid_out |=>
      !dly_valid_out [*8] ##1 !dly_valid_out)
      else $error("delay words closer than ten clocks");
   chk_xmit_space: assert property (xmit_valid_out |=>
      !xmit_valid_out) else $error("transmit words back to back");

   // Main scenarios reached
   cov_term: cover property (term_reset_out);
   cov_dly: cover property (dly_valid_out);
   cov_xmit: cover property (xmit_valid_out);
   cov_hold: cover property ($rose(hold_out));
endmodule

bind dscp_ctrl dscp_ctrl_assertions u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .hold_out(hold_out), .dly_valid_out(dly_valid_out),
   .xmit_valid_out(xmit_valid_out), .term_reset_out(term_reset_out),
   .host_ctl_out(host_ctl_out), .entry_block_out(entry_block_out));

// [tb/dscp_host_model.sv]
// Purpose: Host computer sending clocked serial words
// Assumes: 80 ns bit period, phase free of the system clock
// Notes:   Clock rests low between words, never runs free
module dscp_host_model (
   // Serial link to the device
   output logic      hclk_out,
   output logic      hdat_out,
   // Word clock stop from the device
   input  wire logic hold_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle link at time zero
   initial begin
      hclk_out = 1'b0;
      hdat_out = 1'b0;
   end

   // One framed word, MSB first, data set up mid low phase
   task automatic send(input logic [31:0] w);
      wait (hold_in === 1'b0);
      #13;
      for (int i = 31; i >= 0; i--) begin
         hdat_out = w[i];
         #20 hclk_out = 1'b1;
         #40 hclk_out = 1'b0;
         #20;
      end
      // No pull on data: show the inverse once released
      hdat_out = ~w[0];
      #300;
   endtask
endmodule

// [tb/dscp_ctrl_tb.sv]
// Purpose: Self-checking bench of the delay system control path
// Assumes: Host link at 80 ns per bit, sequencer at full length
// Notes:   Pass/fail data only random after the mux checks
`include "dscp_map.svh"
module dscp_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, rst_in, bt, dt, su, xc1, xc2, rd, wr;
   logic        hclk, hdat, hold, dv, xv, hctl, blk, trst, wreq, alm, hit;
   logic [53:0] pf_a, pf_b;
   logic [15:0] tsa, tsb;
   logic [19:0] mult;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, q;
   int          miscompares, cmp_count, n_dv, n_xv, n_tr, n_hit;

   dscp_host_model host (.hclk_out(hclk), .hdat_out(hdat), .hold_in(hold));
   dscp_ctrl dut (
      .clk_in(clk_in), .rst_in(rst_in), .hclk_in(hclk), .hdat_in(hdat),
      .bt_in(bt), .dt_in(dt), .su_in(su), .hold_out(hold),
      .pf_a_in(pf_a), .pf_b_in(pf_b), .xc1_in(xc1), .xc2_in(xc2),
      .dly_word_out(), .dly_valid_out(dv), .test_a_out(tsa),
      .test_b_out(tsb),
      .mult_in(mult), .xmit_word_out(), .xmit_valid_out(xv),
      .cmp_hit_out(hit), .alarm_out(alm), .host_ctl_out(hctl),
      .entry_block_out(blk), .term_reset_out(trst),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq));

   always #4 clk_in = ~clk_in;

   // Pulse counters and free-running multiplier data
   always @(posedge clk_in) begin
      n_dv += int'(dv === 1'b1);
      n_xv += int'(xv === 1'b1);
      n_tr += int'(trst === 1'b1);
      n_hit += int'(xv === 1'b1 && hit === 1'b1);
      mult <= 20'($urandom);
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Avalon cycle held until waitrequest is sampled low
   task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      {rd, wr} <= {!w, w};
      do begin
         @(posedge clk_in);
         n++;
      end while (wreq !== 1'b0 && n < 100);
      q = rdata;
      {rd, wr} <= 2'b00;
      if (wreq !== 1'b0) miscompares++;
   endtask

   // Tick pin held long enough for the synchroniser
   task tick(input bit d);
      if (d) dt <= 1'b1;
      else bt <= 1'b1;
      repeat (6) @(posedge clk_in);
      {bt, dt} <= 2'b00;
   endtask

   task wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Host word: leading one, route in 23..20, bit 30 fixes parity
   function logic [31:0] mk(logic [3:0] r, logic [19:0] p, bit good);
      logic [31:0] w;
      w = {2'b10, 6'h00, r, p};
      w[30] = (^w) ^ good;
      return w;
   endfunction

   function logic [31:0] mx(int a, int b, int o);
      return {10'h000, 6'(o), 2'h0, 6'(b), 2'h0, 6'(a)};
   endfunction

   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog: the tests need about 28k cycles
   initial begin
      #600000;
      miscompares++;
      final_report();
   end

   // Main sequence
   initial begin
      logic [31:0] v;
      {clk_in, bt, dt, su, xc1, xc2, rd, wr} = '0;
      {pf_a, pf_b, mult, addr, wdata} = '0;
      rst_in = 1'b1;
      void'($urandom(29));
      wt(8);
      rst_in <= 1'b0;
      @(posedge clk_in);
      chk({hold, dv, xv, hctl, blk, trst, wreq}, 32'h1);
      bus(1, `DSCP_R_CTRL, 32'h302);
      bus(0, `DSCP_R_CTRL, 0);
      chk(q, 32'h302);
      for (int i = 0; i < 6; i++) begin
         v = mx($urandom % 54, $urandom % 54, $urandom % 54);
         bus(1, `DSCP_R_MUX, v);
         bus(0, `DSCP_R_MUX, 0);
         chk(q, v);
      end
      bus(1, 8'h20, 32'hffff_ffff);
      bus(0, 8'h20, 0);
      chk(q, 0);
      // Bad parity logged, good word leaves the count alone
      host.send(mk(4'h1, 20'h00123, 0));
      bus(0, `DSCP_R_STAT, 0);
      chk(32'(q[14:8]), 32'h1);
      v = $urandom % 16384;
      host.send(mk(4'h1, 20'(v), 1));
      bus(0, `DSCP_R_STAT, 0);
      chk(32'(q[14:8]), 32'h1);
      // Observation start
      host.send(mk(4'h0, 20'h00001, 1));
      wt(10);
      chk({hctl, blk}, 32'h3);
      chk(n_tr, 1);
      // Both test outputs watch slot 1, the only good delay word
      bus(1, `DSCP_R_MUX, mx(1, 1, 0));
      n_dv = 0;
      tick(0);
      wt(700);
      chk(n_dv, 54);
      chk({tsa, tsb}, {2{16'(v) - `DSCP_TEST_OFS}});
      // Period tick: mux step and sequencer cycle
      bus(1, `DSCP_R_MUX, mx(5, 7, 9));
      n_xv = 0;
      n_hit = 0;
      tick(1);
      wt(100);
      bus(0, `DSCP_R_MUX, 0);
      chk(q, mx(6, 8, 10));
      bus(0, `DSCP_R_STAT, 0);
      chk(32'(q[22:21]), 32'(dscp_pkg::SEQ_LOAD));
      for (int i = 0; i < 20000 && n_xv < 351; i++) @(posedge clk_in);
      wt(20);
      chk(n_xv, 351);
      // Three-bit compare, target 0: every eighth of addresses 0..350
      chk(n_hit, 44);
      // Observation end: entry blocked two more short ticks
      host.send(mk(4'h0, 20'h00000, 1));
      wt(10);
      chk({hctl, blk}, 32'h1);
      tick(0);
      wt(600);
      chk(blk, 1);
      tick(0);
      wt(600);
      chk(blk, 0);
      // Random pass/fail traffic with strobes, then clears
      for (int i = 0; i < 3; i++) begin
         // Alarm follows any fail held from the last short tick
         if (i == 2) v = 32'(|(pf_a | pf_b));
         pf_a <= 54'({$urandom, $urandom});
         pf_b <= 54'({$urandom, $urandom});
         xc1 <= 1'($urandom);
         xc2 <= 1'($urandom);
         tick(i == 2);
         wt(600);
      end
      {xc1, xc2} <= 2'b00;
      chk(alm, v);
      bus(1, `DSCP_R_CTRL, 32'hc);
      for (int i = 0; i < 20000 && n_xv < 702; i++) @(posedge clk_in);
      chk(n_xv, 702);
      // Startup pulse clears the mux registers
      bus(1, `DSCP_R_MUX, mx(3, 4, 5));
      su <= 1'b1;
      wt(8);
      su <= 1'b0;
      wt(8);
      bus(0, `DSCP_R_MUX, 0);
      chk(q, 0);
      final_report();
   end
endmodule
